// ---- src/logger_pkg.sv ----
`default_nettype none
package logger_pkg;

    localparam int unsigned NUM_AXES      = 8;
    localparam int unsigned AXIS_W        = 3;
    localparam int unsigned NUM_CH        = 8;
    localparam int unsigned CH_W          = 3;
    localparam int unsigned NUM_SAMPLES   = 200;
    localparam int unsigned SAMP_W        = 8;
    localparam int unsigned DATA_W        = 32;
    localparam int unsigned CLK_HZ        = 100_000_000;
    localparam int unsigned CYC_PER_MS    = CLK_HZ / 1000;
    localparam int unsigned MIN_SAMPLE_DIV = 16;
    localparam int unsigned MEM_DEPTH     = NUM_CH * NUM_SAMPLES;
    localparam int unsigned MEM_AW        = 11;

    // Register byte offsets
    localparam logic [11:0] OFF_CTRL      = 12'h000;
    localparam logic [11:0] OFF_STATUS    = 12'h004;
    localparam logic [11:0] OFF_TRIG_AXIS = 12'h008;
    localparam logic [11:0] OFF_PERIOD    = 12'h00C;
    localparam logic [11:0] OFF_DELAY     = 12'h010;
    localparam logic [11:0] OFF_XFER_EN   = 12'h014;
    localparam logic [11:0] OFF_RD_PTR    = 12'h018;
    localparam logic [11:0] OFF_RD_DATA   = 12'h01C;
    localparam logic [11:0] OFF_CH_BASE   = 12'h020;
    localparam logic [11:0] OFF_CH_LAST   = 12'h03C;

    // CTRL bits
    localparam int unsigned CTRL_ARM_BIT  = 0;
    localparam int unsigned CTRL_ABORT_BIT = 1;

    // STATUS bits
    localparam int unsigned ST_ARMED_BIT  = 0;
    localparam int unsigned ST_BUSY_BIT   = 1;
    localparam int unsigned ST_DONE_BIT   = 2;
    localparam int unsigned ST_ERR_BIT    = 3;

    // Channel select field: [3:0] source, [6:4] axis, [7] enable
    localparam int unsigned CHSEL_SRC_LSB = 0;
    localparam int unsigned CHSEL_AX_LSB  = 4;
    localparam int unsigned CHSEL_EN_BIT  = 7;

    localparam logic [DATA_W-1:0] SLVERR_DATA = 32'hDEADBEEF;

    typedef enum logic [3:0] {
        SRC_POS_ERR   = 4'h0,
        SRC_CMD_POS   = 4'h1,
        SRC_ENC_POS   = 4'h2,
        SRC_INT_ERR   = 4'h3,
        SRC_ANA_CMD   = 4'h4,
        SRC_ACC_FF    = 4'h5,
        SRC_AIN1      = 4'h6,
        SRC_AIN2      = 4'h7,
        SRC_ENC_VEL   = 4'h8,
        SRC_EVENT1    = 4'h9,
        SRC_EVENT2    = 4'hA,
        SRC_LIM_POS   = 4'hB,
        SRC_LIM_NEG   = 4'hC,
        SRC_CMD_VEL   = 4'hD
    } src_t;

    typedef enum logic [2:0] {
        ST_IDLE    = 3'b000,
        ST_ARMED   = 3'b001,
        ST_DELAY   = 3'b010,
        ST_CAPTURE = 3'b011,
        ST_DONE    = 3'b100
    } log_state_t;

    // Per-axis live motion quantities
    typedef struct packed {
        logic signed [DATA_W-1:0] cmd_pos;
        logic signed [DATA_W-1:0] enc_pos;
        logic signed [DATA_W-1:0] int_err;
        logic signed [DATA_W-1:0] ana_cmd;
        logic signed [DATA_W-1:0] acc_ff;
        logic signed [DATA_W-1:0] ain_pos;
        logic signed [DATA_W-1:0] ain_neg;
        logic signed [DATA_W-1:0] enc_vel;
        logic signed [DATA_W-1:0] cmd_vel;
        logic                     event1;
        logic                     event2;
        logic                     lim_pos;
        logic                     lim_neg;
        logic                     ain_diff;
        logic                     moving;
    } axis_live_t;

    typedef struct packed {
        logic              psel;
        logic              penable;
        logic              pwrite;
        logic [11:0]       paddr;
        logic [DATA_W-1:0] pwdata;
    } apb_req_t;

    typedef struct packed {
        logic              pready;
        logic              pslverr;
        logic [DATA_W-1:0] prdata;
    } apb_rsp_t;

endpackage
`default_nettype wire

// ---- src/log_source_mux.sv ----
`timescale 1ns/1ns
`default_nettype none
module log_source_mux
    import logger_pkg::*;
(
    input  wire logic                        i_sys_clk,
    input  wire logic                        i_srst,
    input  wire axis_live_t [NUM_AXES-1:0]   i_axes,
    input  wire logic [AXIS_W-1:0]           i_axis,
    input  wire logic [3:0]                  i_src,
    output logic [DATA_W-1:0]                o_value
);

    axis_live_t sel_ax;
    logic [DATA_W-1:0] value_next;

    function automatic logic [DATA_W-1:0] bit_word(input logic b);
        bit_word = {{(DATA_W-1){1'b0}}, b};
    endfunction

    always_comb begin
        sel_ax = i_axes[i_axis];
        case (src_t'(i_src))
            SRC_POS_ERR: value_next = sel_ax.cmd_pos - sel_ax.enc_pos;
            SRC_CMD_POS: value_next = sel_ax.cmd_pos;
            SRC_ENC_POS: value_next = sel_ax.enc_pos;
            SRC_INT_ERR: value_next = sel_ax.int_err;
            SRC_ANA_CMD: value_next = sel_ax.ana_cmd;
            SRC_ACC_FF:  value_next = sel_ax.acc_ff;
            SRC_AIN1:    value_next = sel_ax.ain_diff ? sel_ax.ain_pos - sel_ax.ain_neg
                                                      : sel_ax.ain_pos;
            SRC_AIN2:    value_next = sel_ax.ain_diff ? '0 : sel_ax.ain_neg;
            SRC_ENC_VEL: value_next = sel_ax.enc_vel;
            SRC_EVENT1:  value_next = bit_word(sel_ax.event1);
            SRC_EVENT2:  value_next = bit_word(sel_ax.event2);
            SRC_LIM_POS: value_next = bit_word(sel_ax.lim_pos);
            SRC_LIM_NEG: value_next = bit_word(sel_ax.lim_neg);
            SRC_CMD_VEL: value_next = sel_ax.cmd_vel;
            default:     value_next = '0;
        endcase
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            o_value <= '0;
        end else begin
            o_value <= value_next;
        end
    end

endmodule
`default_nettype wire

// ---- src/motion_triggered_data_logger.sv ----
// Summary of operation
// - Capture up to eight channels once the armed trigger fires.
// - Store exactly 200 samples per logged channel.
// - Trigger on motion from host commands or stored program alike.
// - At most eight channel slots exist whatever axes are chosen.
// - Trigger fires when motion starts on the selected trigger axis.
// - Capture duration in clock cycles sets the sample spacing.
// - Wait the programmed milliseconds after trigger before first sample.
// - Writing configuration and arm bit arms the motion trigger.
// - Each channel picks axis and one of fourteen quantity sources.
// - Position error is commanded minus encoder position.
// - Commanded and encoder position sources pass positions through.
// - Integration error source gives integral output share.
// - Analog command source gives commanded torque or output voltage.
// - Analog input one is positive input or differential value.
// - Analog input two is negative input, single-ended only.
// - Encoder velocity source gives measured velocity.
// - Event and limit sources record input logic state each sample.
// - Commanded velocity source gives commanded velocity.
// - Readout allowed only once capture is done; host enables each channel.
// - Host readout returns samples of enabled channels.
`timescale 1ns/1ns
`default_nettype none
module motion_triggered_data_logger
    import logger_pkg::*;
(
    input  wire logic                        i_sys_clk,
    input  wire logic                        i_srst,
    input  wire logic                        i_psel,
    input  wire logic                        i_penable,
    input  wire logic                        i_pwrite,
    input  wire logic [11:0]                 i_paddr,
    input  wire logic [DATA_W-1:0]           i_pwdata,
    output logic [DATA_W-1:0]                o_prdata,
    output logic                             o_pready,
    output logic                             o_pslverr,
    input  wire axis_live_t [NUM_AXES-1:0]   i_axes
);

    apb_req_t          req;
    logic              wr_en;
    logic              rd_en;
    logic              access;

    logic [7:0]        ch_sel_reg [NUM_CH];
    logic [AXIS_W-1:0] trig_axis_reg;
    logic [DATA_W-1:0] period_reg;
    logic [15:0]       delay_reg;
    logic [NUM_CH-1:0] xfer_en_reg;
    logic [MEM_AW-1:0] rd_ptr_reg;
    logic              err_reg;
    logic [DATA_W-1:0] prdata_reg;

    log_state_t        state_reg;
    log_state_t        state_next;
    logic              moving_d_reg;
    logic              motion_start;
    logic [DATA_W-1:0] tick_cnt_reg;
    logic [DATA_W-1:0] sample_div;
    logic [15:0]       ms_cnt_reg;
    logic [16:0]       cyc_cnt_reg;
    logic [SAMP_W-1:0] samp_idx_reg;
    logic [CH_W-1:0]   ch_idx_reg;
    logic              sweep_reg;
    logic              delay_done;
    logic              tick;
    logic [DATA_W-1:0] src_value;
    logic [DATA_W-1:0] mem [MEM_DEPTH];
    logic              arm_wr;
    logic              abort_wr;
    logic              rd_legal;
    logic [DATA_W-1:0] rd_word;
    logic [CH_W-1:0]   rd_ch;
    logic              cfg_ok;

    function automatic logic [MEM_AW-1:0] mem_addr(input logic [CH_W-1:0] ch,
                                                   input logic [SAMP_W-1:0] idx);
        mem_addr = MEM_AW'(ch * NUM_SAMPLES + idx);
    endfunction

    function automatic logic is_ch_addr(input logic [11:0] a);
        is_ch_addr = (a >= OFF_CH_BASE) && (a <= OFF_CH_LAST) && (a[1:0] == 2'b00);
    endfunction

    function automatic logic [CH_W-1:0] ch_of_addr(input logic [11:0] a);
        ch_of_addr = CH_W'((a - OFF_CH_BASE) >> 2);
    endfunction

    assign req = '{psel: i_psel, penable: i_penable, pwrite: i_pwrite, paddr: i_paddr, pwdata: i_pwdata};
    assign access = req.psel && req.penable;
    assign wr_en = access && req.pwrite;
    assign rd_en = access && !req.pwrite;
    assign o_pready = 1'b1;
    assign o_prdata = prdata_reg;
    assign o_pslverr = err_reg && access;

    assign arm_wr = wr_en && (req.paddr == OFF_CTRL) && req.pwdata[CTRL_ARM_BIT];
    assign abort_wr = wr_en && (req.paddr == OFF_CTRL) && req.pwdata[CTRL_ABORT_BIT];
    assign cfg_ok = (state_reg == ST_IDLE) || (state_reg == ST_DONE);
    assign rd_ch = CH_W'(rd_ptr_reg / NUM_SAMPLES);
    assign rd_legal = (state_reg == ST_DONE) && xfer_en_reg[rd_ch];

    log_source_mux u_mux (
        .i_sys_clk (i_sys_clk),
        .i_srst    (i_srst),
        .i_axes    (i_axes),
        .i_axis    (ch_sel_reg[ch_idx_reg][CHSEL_AX_LSB +: AXIS_W]),
        .i_src     (ch_sel_reg[ch_idx_reg][CHSEL_SRC_LSB +: 4]),
        .o_value   (src_value)
    );

    // Configuration registers, writable only while idle or done; transfer enable writable at any time
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            for (int i = 0; i < NUM_CH; i++) begin
                ch_sel_reg[i] <= 8'h00;
            end
            trig_axis_reg <= '0;
            period_reg    <= '0;
            delay_reg     <= '0;
            xfer_en_reg   <= '0;
        end else if (wr_en && cfg_ok) begin
            if (is_ch_addr(req.paddr)) begin
                ch_sel_reg[ch_of_addr(req.paddr)] <= req.pwdata[7:0];
            end
            case (req.paddr)
                OFF_TRIG_AXIS: trig_axis_reg <= req.pwdata[AXIS_W-1:0];
                OFF_PERIOD:    period_reg <= req.pwdata;
                OFF_DELAY:     delay_reg <= req.pwdata[15:0];
                OFF_XFER_EN:   xfer_en_reg <= req.pwdata[NUM_CH-1:0];
                default: ;
            endcase
        end else if (wr_en && (req.paddr == OFF_XFER_EN)) begin
            xfer_en_reg <= req.pwdata[NUM_CH-1:0];
        end
    end

    // Readout pointer, auto-increment on data read
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            rd_ptr_reg <= '0;
        end else if (wr_en && (req.paddr == OFF_RD_PTR)) begin
            rd_ptr_reg <= req.pwdata[MEM_AW-1:0];
        end else if (rd_en && (req.paddr == OFF_RD_DATA) && (rd_ptr_reg < MEM_AW'(MEM_DEPTH - 1))) begin
            rd_ptr_reg <= rd_ptr_reg + MEM_AW'(1);
        end
    end

    // Read data and error
    always_comb begin
        rd_word = mem[rd_ptr_reg];
        err_reg = 1'b0;
        if (req.paddr == OFF_RD_DATA && !req.pwrite && !rd_legal) begin
            err_reg = 1'b1;
        end
        if (req.pwrite && !cfg_ok && req.paddr != OFF_CTRL && req.paddr != OFF_XFER_EN
            && req.paddr != OFF_RD_PTR) begin
            err_reg = 1'b1;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            prdata_reg <= '0;
        end else if (req.psel && !req.penable && !req.pwrite) begin
            case (req.paddr)
                OFF_CTRL:      prdata_reg <= '0;
                OFF_STATUS:    prdata_reg <= {28'h0000000, 1'b0, state_reg == ST_DONE,
                                              (state_reg == ST_DELAY) || (state_reg == ST_CAPTURE),
                                              state_reg == ST_ARMED};
                OFF_TRIG_AXIS: prdata_reg <= DATA_W'(trig_axis_reg);
                OFF_PERIOD:    prdata_reg <= period_reg;
                OFF_DELAY:     prdata_reg <= DATA_W'(delay_reg);
                OFF_XFER_EN:   prdata_reg <= DATA_W'(xfer_en_reg);
                OFF_RD_PTR:    prdata_reg <= DATA_W'(rd_ptr_reg);
                OFF_RD_DATA:   prdata_reg <= rd_legal ? rd_word : '0;
                default: begin
                    if (is_ch_addr(req.paddr)) begin
                        prdata_reg <= DATA_W'(ch_sel_reg[ch_of_addr(req.paddr)]);
                    end else begin
                        prdata_reg <= '0;
                    end
                end
            endcase
        end
    end

    // Motion start detection on trigger axis
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            moving_d_reg <= 1'b0;
        end else begin
            moving_d_reg <= i_axes[trig_axis_reg].moving;
        end
    end
    assign motion_start = i_axes[trig_axis_reg].moving && !moving_d_reg;

    // State machine
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE, ST_DONE: if (arm_wr) state_next = ST_ARMED;
            ST_ARMED:   if (abort_wr) state_next = ST_IDLE;
                        else if (motion_start) state_next = ST_DELAY;
            ST_DELAY:   if (abort_wr) state_next = ST_IDLE;
                        else if (delay_done) state_next = ST_CAPTURE;
            ST_CAPTURE: if (abort_wr) state_next = ST_IDLE;
                        else if (sweep_reg && ch_idx_reg == CH_W'(NUM_CH - 1)
                                 && samp_idx_reg == SAMP_W'(NUM_SAMPLES - 1)) state_next = ST_DONE;
            default:    state_next = ST_IDLE;
        endcase
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            state_reg <= ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // Trigger delay in milliseconds
    always_ff @(posedge i_sys_clk) begin
        if (i_srst || state_reg != ST_DELAY) begin
            cyc_cnt_reg <= '0;
            ms_cnt_reg  <= '0;
        end else if (cyc_cnt_reg == 17'(CYC_PER_MS - 1)) begin
            cyc_cnt_reg <= '0;
            ms_cnt_reg  <= ms_cnt_reg + 16'h0001;
        end else begin
            cyc_cnt_reg <= cyc_cnt_reg + 17'h00001;
        end
    end
    assign delay_done = (ms_cnt_reg == delay_reg);

    // Sample tick: period_reg is capture duration in clock cycles
    assign sample_div = (period_reg / NUM_SAMPLES == 0) ? MIN_SAMPLE_DIV : period_reg / NUM_SAMPLES;
    assign tick = (state_reg == ST_CAPTURE) && !sweep_reg && (tick_cnt_reg == 0);

    always_ff @(posedge i_sys_clk) begin
        if (i_srst || state_reg != ST_CAPTURE) begin
            tick_cnt_reg <= '0;
        end else if (tick_cnt_reg == sample_div - 1) begin
            tick_cnt_reg <= '0;
        end else begin
            tick_cnt_reg <= tick_cnt_reg + 32'h00000001;
        end
    end

    // Channel sweep per sample: one channel per cycle, mux latency one
    always_ff @(posedge i_sys_clk) begin
        if (i_srst || state_reg != ST_CAPTURE) begin
            sweep_reg    <= 1'b0;
            ch_idx_reg   <= '0;
            samp_idx_reg <= '0;
        end else if (tick) begin
            sweep_reg <= 1'b1;
        end else if (sweep_reg) begin
            if (ch_idx_reg == CH_W'(NUM_CH - 1)) begin
                sweep_reg  <= 1'b0;
                ch_idx_reg <= '0;
                samp_idx_reg <= samp_idx_reg + SAMP_W'(1);
            end else begin
                ch_idx_reg <= ch_idx_reg + CH_W'(1);
            end
        end
    end

    // Sample storage
    logic              wr_pend_reg;
    logic [MEM_AW-1:0] wr_addr_reg;
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= '0;
        end else begin
            wr_pend_reg <= sweep_reg && ch_sel_reg[ch_idx_reg][CHSEL_EN_BIT];
            wr_addr_reg <= mem_addr(ch_idx_reg, samp_idx_reg);
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (wr_pend_reg) begin
            mem[wr_addr_reg] <= src_value;
        end
    end

endmodule
`default_nettype wire

// ---- dv/axis_motion_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module axis_motion_model
    import logger_pkg::*;
(
    output var axis_live_t [NUM_AXES-1:0] o_axes
);
    initial o_axes = '0;
    // Live quantities, held steady until the next load
    task automatic load(input axis_live_t [NUM_AXES-1:0] v);
        o_axes <= v;
    endtask
    // Motion start or stop, host command or stored program alike
    task automatic move(input logic [AXIS_W-1:0] a, input logic on);
        o_axes[a].moving <= on;
    endtask
endmodule
`default_nettype wire

// ---- dv/logger_chk.sv ----
`timescale 1ns/1ns
`default_nettype none
module logger_chk
    import logger_pkg::*;
(
    input wire logic                      i_sys_clk,
    input wire logic                      i_srst,
    input wire logic                      i_psel,
    input wire logic                      i_penable,
    input wire logic                      i_pwrite,
    input wire logic [11:0]               i_paddr,
    input wire logic [DATA_W-1:0]         i_pwdata,
    input wire logic [DATA_W-1:0]         o_prdata,
    input wire logic                      o_pready,
    input wire logic                      o_pslverr,
    input wire axis_live_t [NUM_AXES-1:0] i_axes
);
    logic acc;
    logic cfg;
    logic wr_arm;
    logic wr_abort;
    logic rd_stat;
    logic capt_reg;
    assign acc = i_psel && i_penable;
    assign cfg = i_paddr inside {OFF_TRIG_AXIS, OFF_PERIOD, OFF_DELAY}
        || (i_paddr >= OFF_CH_BASE && i_paddr <= OFF_CH_LAST);
    assign wr_arm = acc && i_pwrite && i_paddr == OFF_CTRL && i_pwdata[CTRL_ARM_BIT] && !i_pwdata[CTRL_ABORT_BIT];
    assign wr_abort = acc && i_pwrite && i_paddr == OFF_CTRL && i_pwdata[CTRL_ABORT_BIT];
    assign rd_stat = acc && !i_pwrite && i_paddr == OFF_STATUS;
    // Capture in progress, cleared once status shows idle or done
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            capt_reg <= 1'b0;
        end else if (wr_arm) begin
            capt_reg <= 1'b1;
        end else if (wr_abort || (rd_stat && !o_prdata[ST_ARMED_BIT] && !o_prdata[ST_BUSY_BIT])) begin
            capt_reg <= 1'b0;
        end
    end
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_srst);
    property p_zero_wait; i_psel && !i_penable |=> o_pready; endproperty
    a_zero_wait: assert property (p_zero_wait) else $error("pready low in access");
    property p_cfg_refused; acc && i_pwrite && cfg && capt_reg |-> o_pslverr; endproperty
    a_cfg_refused: assert property (p_cfg_refused) else $error("config write taken while armed");
    property p_cfg_taken; acc && i_pwrite && cfg && !capt_reg |-> !o_pslverr; endproperty
    a_cfg_taken: assert property (p_cfg_taken) else $error("config write refused while idle");
    property p_early_read;
        acc && !i_pwrite && i_paddr == OFF_RD_DATA && capt_reg |-> o_pslverr && o_prdata == '0;
    endproperty
    a_early_read: assert property (p_early_read) else $error("sample read before done");
    property p_unmapped; acc && !i_pwrite && i_paddr > OFF_CH_LAST |-> !o_pslverr && o_prdata == '0; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_armed_seen; wr_arm ##[2:4] rd_stat |-> o_prdata[ST_ARMED_BIT]; endproperty
    a_armed_seen: assert property (p_armed_seen) else $error("arm not shown in status");
    property p_abort; wr_abort ##[2:4] rd_stat |-> o_prdata[2:0] == 3'h0; endproperty
    a_abort: assert property (p_abort) else $error("abort left logger active");
    property p_done_clears;
        rd_stat && o_prdata[ST_DONE_BIT] |-> !o_prdata[ST_ARMED_BIT] && !o_prdata[ST_BUSY_BIT];
    endproperty
    a_done_clears: assert property (p_done_clears) else $error("done while armed or busy");
    property p_rd_hold; !(i_psel && !i_penable && !i_pwrite) |=> $stable(o_prdata); endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read data moved without read");
    property p_rst_out; $fell(i_srst) |-> o_prdata == '0 && !o_pslverr; endproperty
    a_rst_out: assert property (p_rst_out) else $error("outputs not cleared by reset");
    c_arm: cover property (wr_arm);
    c_sample: cover property (acc && !i_pwrite && i_paddr == OFF_RD_DATA && !o_pslverr);
    c_done: cover property (rd_stat && o_prdata[ST_DONE_BIT]);
endmodule
bind motion_triggered_data_logger logger_chk u_chk (.i_sys_clk(i_sys_clk), .i_srst(i_srst), .i_psel(i_psel),
    .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
    .o_pready(o_pready), .o_pslverr(o_pslverr), .i_axes(i_axes));
`default_nettype wire

// ---- dv/motion_triggered_data_logger_tb.sv ----
`timescale 1ns/1ns
`default_nettype none
module motion_triggered_data_logger_tb
    import logger_pkg::*;
;
    logic                      i_sys_clk;
    logic                      i_srst;
    logic                      i_psel;
    logic                      i_penable;
    logic                      i_pwrite;
    logic [11:0]               i_paddr;
    logic [DATA_W-1:0]         i_pwdata;
    logic [DATA_W-1:0]         o_prdata;
    logic                      o_pready;
    logic                      o_pslverr;
    axis_live_t [NUM_AXES-1:0] axes;
    axis_live_t [NUM_AXES-1:0] lv;
    logic [31:0]               seed;
    logic [31:0]               rv;
    logic [31:0]               t;
    logic                      re;
    logic [3:0]                src [NUM_CH];
    logic [2:0]                ax [NUM_CH];
    logic [2:0]                trig;
    logic [7:0]                mask;
    int                        num_errors;
    int                        n_tests;

    initial begin
        i_sys_clk = 1'b0;
        forever #5 i_sys_clk = ~i_sys_clk;
    end

    axis_motion_model pm (.o_axes(axes));
    motion_triggered_data_logger dut (.i_sys_clk(i_sys_clk), .i_srst(i_srst), .i_psel(i_psel),
        .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
        .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr), .i_axes(axes));

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // Value a slot should hold for one source of one axis
    function automatic logic [31:0] expv(input axis_live_t a, input logic [3:0] s);
        case (s)
            4'h0: return a.cmd_pos - a.enc_pos;
            4'h1: return a.cmd_pos;
            4'h2: return a.enc_pos;
            4'h3: return a.int_err;
            4'h4: return a.ana_cmd;
            4'h5: return a.acc_ff;
            4'h6: return a.ain_diff ? a.ain_pos - a.ain_neg : a.ain_pos;
            4'h7: return a.ain_diff ? 32'h0 : a.ain_neg;
            4'h8: return a.enc_vel;
            4'h9: return {31'h0, a.event1};
            4'hA: return {31'h0, a.event2};
            4'hB: return {31'h0, a.lim_pos};
            4'hC: return {31'h0, a.lim_neg};
            default: return a.cmd_vel;
        endcase
    endfunction

    task automatic end_of_test();
        $display("Comparisons %0d, mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask

    // One APB transfer: setup, then access until pready
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        int k;
        @(posedge i_sys_clk);
        i_psel <= 1'b1;
        i_penable <= 1'b0;
        i_pwrite <= w;
        i_paddr <= a;
        i_pwdata <= d;
        @(posedge i_sys_clk);
        i_penable <= 1'b1;
        for (k = 0; k < 16; k++) begin
            @(posedge i_sys_clk);
            if (o_pready === 1'b1) break;
        end
        r = o_prdata;
        e = o_pslverr;
        i_psel <= 1'b0;
        i_penable <= 1'b0;
        if (k == 16) begin
            chk("pready", 32'h1, 32'h0);
            end_of_test();
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic ee);
        apb(1'b1, a, d, rv, re);
        chk("write_err", {31'h0, ee}, {31'h0, re});
    endtask

    task automatic stat(input logic [2:0] e);
        apb(1'b0, OFF_STATUS, 32'h0, rv, re);
        chk("status", {29'h0, e}, {29'h0, rv[2:0]});
    endtask

    task automatic wait_done();
        int k;
        for (k = 0; k < 3000; k++) begin
            apb(1'b0, OFF_STATUS, 32'h0, rv, re);
            if (rv[ST_DONE_BIT] === 1'b1) break;
        end
        chk("done", 32'h1, {31'h0, rv[ST_DONE_BIT]});
        if (k == 3000) end_of_test();
    endtask

    initial begin
        seed = 32'h866B9714;
        num_errors = 0;
        n_tests = 0;
        i_srst = 1'b1;
        i_psel = 1'b0;
        i_penable = 1'b0;
        i_pwrite = 1'b0;
        i_paddr = 12'h000;
        i_pwdata = 32'h0;
        repeat (2) @(posedge i_sys_clk);
        i_srst <= 1'b0;
        chk("rst_prdata", 32'h0, o_prdata);
        chk("rst_pready", 32'h1, {31'h0, o_pready});
        apb(1'b0, 12'h040, 32'h0, rv, re);
        chk("unmapped", 32'h0, rv);
        chk("unmapped_err", 32'h0, {31'h0, re});
        wr(OFF_CTRL, 32'h1, 1'b0);
        stat(3'h1);
        wr(OFF_CTRL, 32'h2, 1'b0);
        stat(3'h0);
        $display("Test reset and abort finished");
        for (int run = 0; run < 2; run++) begin
            for (int a = 0; a < NUM_AXES; a++) begin
                t = rnd();
                lv[a] = {rnd(), rnd(), rnd(), rnd(), rnd(), rnd(), rnd(), rnd(), rnd(), t[5:1], 1'b0};
            end
            pm.load(lv);
            t = rnd();
            trig = t[2:0];
            wr(OFF_TRIG_AXIS, {29'h0, trig}, 1'b0);
            wr(OFF_PERIOD, 32'h00000FA0, 1'b0);
            wr(OFF_DELAY, 32'h0, 1'b0);
            for (int s = 0; s < NUM_CH; s++) begin
                t = rnd();
                src[s] = (run == 1 && s < 6) ? 4'(8 + s) : 4'(s);
                ax[s] = t[2:0];
                wr(OFF_CH_BASE + 12'(4 * s), {24'h0, 1'b1, ax[s], src[s]}, 1'b0);
            end
            wr(OFF_CTRL, 32'h1, 1'b0);
            wr(OFF_PERIOD, 32'h00000FA0, 1'b1);
            apb(1'b0, OFF_RD_DATA, 32'h0, rv, re);
            chk("early_read_err", 32'h1, {31'h0, re});
            pm.move(trig + 3'h1, 1'b1);
            stat(3'h1);
            pm.move(trig, 1'b1);
            wait_done();
            pm.load(lv);
            @(posedge i_sys_clk);
            pm.move(trig, 1'b1);
            stat(3'h4);
            t = rnd();
            mask = t[7:0] | 8'h01;
            wr(OFF_XFER_EN, {24'h0, mask}, 1'b0);
            for (int s = 0; s < NUM_CH; s++) begin
                wr(OFF_RD_PTR, 32'(s * NUM_SAMPLES), 1'b0);
                if (mask[s]) begin
                    for (int i = 0; i < NUM_SAMPLES; i++) begin
                        apb(1'b0, OFF_RD_DATA, 32'h0, rv, re);
                        chk("sample", expv(lv[ax[s]], src[s]), rv);
                        chk("sample_err", 32'h0, {31'h0, re});
                    end
                end else begin
                    apb(1'b0, OFF_RD_DATA, 32'h0, rv, re);
                    chk("masked_err", 32'h1, {31'h0, re});
                end
            end
            $display("Test capture run %0d finished", run);
        end
        end_of_test();
    end
endmodule
`default_nettype wire
